/* common/les_pkg.sv */
// Shared constants and types of the laser enable interlock sequencer.
// Assumes one 10 MHz clock and an APB slave with 32-bit data.

package les_pkg;

	// ============================================================
	// Timing
	localparam int unsigned CLK_HZ            = 10_000_000;
	localparam int unsigned RESTART_DELAY_S   = 5;
	localparam int unsigned RESTART_DELAY_CYC = RESTART_DELAY_S * CLK_HZ;
	localparam int unsigned DEBOUNCE_US       = 100;
	localparam int unsigned DEBOUNCE_CYC      = DEBOUNCE_US * (CLK_HZ / 1_000_000);
	localparam int unsigned PWM_CNT_W         = 16;

	// ============================================================
	// Register map (byte addresses)
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
	localparam logic [7:0] ADDR_PWM_HIGH = 8'h10;
	localparam logic [7:0] ADDR_PWM_PER  = 8'h14;

	// Control fields
	localparam int unsigned CTRL_KS_BIT  = 0;
	localparam logic [31:0] CTRL_MASK    = 32'h0000_0001;
	localparam logic [31:0] CTRL_RST     = 32'h0000_0001;

	// Status fields
	localparam int unsigned STAT_PINS_LSB  = 0;
	localparam int unsigned STAT_STATE_LSB = 8;
	localparam int unsigned STAT_RF_BIT    = 12;
	localparam int unsigned STAT_READY_BIT = 13;
	localparam int unsigned STAT_SHUT_BIT  = 14;

	// Interrupt events
	localparam int unsigned IRQ_W          = 4;
	localparam int unsigned IRQ_READY      = 0;
	localparam int unsigned IRQ_IL_LOST    = 1;
	localparam int unsigned IRQ_DELAY_DONE = 2;
	localparam int unsigned IRQ_RESET_REQ  = 3;
	localparam logic [IRQ_W-1:0] IRQ_RST   = 4'h0;

	// ============================================================
	// Types
	typedef struct packed {
		logic keyswitch_on;
		logic shutter_sw_open;
		logic shutter_req;
		logic interlock;
		logic reset_req;
	} les_pins_type;

	localparam int unsigned PINS_W = $bits(les_pins_type);

	typedef struct packed {
		logic rf_enable;
		logic laser_pwm;
		logic ready;
		logic shutter_open_indication;
	} les_out_type;

	typedef enum logic [1:0] {
		ST_LATCHED = 2'b00,
		ST_HOLD    = 2'b01,
		ST_DELAY   = 2'b10,
		ST_RUN     = 2'b11
	} les_state_type;

	// Word-aligned address match
	function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] off);
		addr_is = (addr[7:2] == off[7:2]);
	endfunction

endpackage

/* core/les_debounce.sv */
// Two-flop synchroniser plus per-bit debounce filter.
// Assumes asynchronous level inputs; outputs are clean levels on pclk.

`timescale 1ns/1ps

module les_debounce #(
	parameter int unsigned WIDTH   = 5,
	parameter int unsigned DEB_CYC = 1000
) (
	input  wire logic             pclk,      // System clock
	input  wire logic             presetn,   // Async reset, active low
	input  wire logic [WIDTH-1:0] async_in,  // Raw isolated inputs
	output logic      [WIDTH-1:0] clean_out  // Debounced levels
);
	localparam int unsigned CW = $clog2(DEB_CYC + 1);
	localparam logic [CW-1:0] CNT_LAST = CW'(DEB_CYC - 1);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] stable_reg;
	logic [WIDTH-1:0] stable_next;
	logic [CW-1:0]    cnt_reg  [WIDTH];
	logic [CW-1:0]    cnt_next [WIDTH];

	// ============================================================
	// Filter: a level must hold for DEB_CYC cycles to be taken
	always_comb begin
		stable_next = stable_reg;
		for (int i = 0; i < WIDTH; i++) begin
			cnt_next[i] = '0;
			if (sync_reg[i] != stable_reg[i]) begin
				if (cnt_reg[i] == CNT_LAST)
					stable_next[i] = sync_reg[i];
				else
					cnt_next[i] = cnt_reg[i] + 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg   <= '0;
			sync_reg   <= '0;
			stable_reg <= '0;
			for (int i = 0; i < WIDTH; i++)
				cnt_reg[i] <= '0;
		end else begin
			meta_reg   <= async_in;
			sync_reg   <= meta_reg;
			stable_reg <= stable_next;
			for (int i = 0; i < WIDTH; i++)
				cnt_reg[i] <= cnt_next[i];
		end
	end

	assign clean_out = stable_reg;

	deb_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(stable_reg) |-> $past(sync_reg) != $past(stable_reg))
		else $error("debounced level moved without a raw difference");

endmodule

/* core/les_sequencer.sv */
// Laser enable interlock sequencer: gates RF driver power and PWM drive.
// Assumes isolated inputs arrive asynchronously; registers sit on APB.

`timescale 1ns/1ps

module les_sequencer
#(
	parameter int unsigned DELAY_CYCLES = les_pkg::RESTART_DELAY_CYC,
	parameter int unsigned DEB_CYCLES   = les_pkg::DEBOUNCE_CYC,
	parameter int unsigned PWM_W        = les_pkg::PWM_CNT_W
) (
	input  wire logic                  pclk,      // APB and core clock
	input  wire logic                  presetn,   // Async reset, active low
	input  wire logic                  psel,      // APB select
	input  wire logic                  penable,   // APB access phase
	input  wire logic                  pwrite,    // APB write
	input  wire logic [7:0]            paddr,     // APB byte address
	input  wire logic [31:0]           pwdata,    // APB write data
	output logic      [31:0]           prdata,    // APB read data
	output logic                       pready,    // APB ready
	output logic                       pslverr,   // APB error, unmapped
	input  wire les_pkg::les_pins_type pins_in,   // Isolated control inputs
	input  wire logic                  pwm_in,    // PWM power command
	output les_pkg::les_out_type       laser_out, // Drive and status
	output logic                       irq        // Level interrupt
);
	import les_pkg::*;

	localparam int unsigned DW = $clog2(DELAY_CYCLES + 1);
	localparam logic [DW-1:0] DELAY_LAST = DW'(DELAY_CYCLES - 1);
	localparam logic [PWM_W-1:0] PWM_ONE = PWM_W'(1);

	function automatic logic [PWM_W-1:0] sat_inc(input logic [PWM_W-1:0] v);
		sat_inc = (&v) ? v : v + PWM_ONE;
	endfunction

	// ============================================================
	// Input conditioning
	logic [PINS_W-1:0] pins_clean;
	les_pins_type      pin;
	les_pins_type      prev_reg;

	les_debounce #(
		.WIDTH   (PINS_W),
		.DEB_CYC (DEB_CYCLES)
	) u_debounce (
		.pclk      (pclk),
		.presetn   (presetn),
		.async_in  (pins_in),
		.clean_out (pins_clean)
	);

	assign pin = les_pins_type'(pins_clean);

	logic pwm_meta_reg;
	logic pwm_sync_reg;
	logic pwm_prev_reg;

	// ============================================================
	// Sequencer state
	les_state_type  state_reg;
	les_state_type  state_next;
	logic [DW-1:0]  delay_cnt_reg;
	logic [DW-1:0]  delay_cnt_next;
	les_out_type    out_reg;
	les_out_type    out_next;
	logic [31:0]    ctrl_reg;
	logic           ks;
	logic           shutter_ok;
	logic           ks_rise;
	logic           il_fall;
	logic [IRQ_W-1:0] events;

	always_comb begin
		ks         = ctrl_reg[CTRL_KS_BIT];
		ks_rise    = pin.keyswitch_on & ~prev_reg.keyswitch_on;
		il_fall    = ~pin.interlock & prev_reg.interlock;
		state_next = state_reg;
		shutter_ok = pin.shutter_req & (~ks | pin.shutter_sw_open);
		if (pin.reset_req) begin
			state_next = ST_HOLD;
		end else begin
			case (state_reg)
				ST_HOLD: begin
					if (!ks)
						state_next = ST_RUN;
					else if (pin.keyswitch_on && pin.interlock)
						state_next = ST_DELAY;
					else
						state_next = ST_LATCHED;
				end
				ST_LATCHED: begin
					if (!ks)
						state_next = ST_RUN;
					else if (ks_rise && pin.interlock)
						state_next = ST_DELAY;
				end
				ST_DELAY: begin
					if (!ks)
						state_next = ST_RUN;
					else if (!pin.interlock || !pin.keyswitch_on)
						state_next = ST_LATCHED;
					else if (delay_cnt_reg == DELAY_LAST)
						state_next = ST_RUN;
				end
				ST_RUN: begin
					if (ks && (!pin.interlock || !pin.keyswitch_on))
						state_next = ST_LATCHED;
				end
				default: state_next = ST_LATCHED;
			endcase
		end
		delay_cnt_next = (state_reg == ST_DELAY) ? delay_cnt_reg + 1'b1 : '0;
		out_next.rf_enable = (state_reg == ST_RUN) & ~pin.reset_req & pin.interlock
			& shutter_ok & (~ks | pin.keyswitch_on);
		out_next.laser_pwm = out_next.rf_enable & pwm_sync_reg;
		out_next.ready = (state_next == ST_DELAY) | (state_next == ST_RUN);
		out_next.shutter_open_indication = shutter_ok;
		events = '0;
		events[IRQ_READY]      = out_next.ready & ~out_reg.ready;
		events[IRQ_IL_LOST]    = il_fall;
		events[IRQ_DELAY_DONE] = (state_reg == ST_DELAY) & (state_next == ST_RUN);
		events[IRQ_RESET_REQ]  = pin.reset_req & ~prev_reg.reset_req;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg     <= ST_LATCHED;
			delay_cnt_reg <= '0;
			out_reg       <= '0;
			prev_reg      <= '0;
		end else begin
			state_reg     <= state_next;
			delay_cnt_reg <= delay_cnt_next;
			out_reg       <= out_next;
			prev_reg      <= pin;
		end
	end

	assign laser_out = out_reg;

	// ============================================================
	// PWM duty measurement
	// Only a synchroniser here: debouncing would eat short pulses at 160 kHz
	logic [PWM_W-1:0] hi_cnt_reg;
	logic [PWM_W-1:0] hi_cnt_next;
	logic [PWM_W-1:0] per_cnt_reg;
	logic [PWM_W-1:0] per_cnt_next;
	logic [PWM_W-1:0] pwm_high_reg;
	logic [PWM_W-1:0] pwm_high_next;
	logic [PWM_W-1:0] pwm_per_reg;
	logic [PWM_W-1:0] pwm_per_next;

	always_comb begin
		pwm_high_next = pwm_high_reg;
		pwm_per_next  = pwm_per_reg;
		if (pwm_sync_reg && !pwm_prev_reg) begin
			pwm_high_next = hi_cnt_reg;
			pwm_per_next  = per_cnt_reg;
			hi_cnt_next   = PWM_ONE;
			per_cnt_next  = PWM_ONE;
		end else begin
			hi_cnt_next   = pwm_sync_reg ? sat_inc(hi_cnt_reg) : hi_cnt_reg;
			per_cnt_next  = sat_inc(per_cnt_reg);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_meta_reg <= 1'b0;
			pwm_sync_reg <= 1'b0;
			pwm_prev_reg <= 1'b0;
			hi_cnt_reg   <= '0;
			per_cnt_reg  <= '0;
			pwm_high_reg <= '0;
			pwm_per_reg  <= '0;
		end else begin
			pwm_meta_reg <= pwm_in;
			pwm_sync_reg <= pwm_meta_reg;
			pwm_prev_reg <= pwm_sync_reg;
			hi_cnt_reg   <= hi_cnt_next;
			per_cnt_reg  <= per_cnt_next;
			pwm_high_reg <= pwm_high_next;
			pwm_per_reg  <= pwm_per_next;
		end
	end

	// ============================================================
	// APB slave and interrupts
	// Zero wait states: the answer is registered in setup, ready in access
	logic [31:0]      ctrl_next;
	logic [IRQ_W-1:0] irq_stat_reg;
	logic [IRQ_W-1:0] irq_stat_next;
	logic [IRQ_W-1:0] irq_mask_reg;
	logic [IRQ_W-1:0] irq_mask_next;
	logic [31:0]      prdata_reg;
	logic [31:0]      prdata_next;
	logic             pready_reg;
	logic             pready_next;
	logic             pslverr_reg;
	logic             pslverr_next;
	logic             irq_reg;
	logic             irq_next;
	logic             setup;
	logic             wr;
	logic             rd;
	logic             hit;
	logic [31:0]      status_word;

	always_comb begin
		setup = psel & ~penable;
		wr    = psel & penable & pready_reg & pwrite;
		rd    = psel & penable & pready_reg & ~pwrite;
		status_word = '0;
		status_word[STAT_PINS_LSB +: PINS_W] = pins_clean;
		status_word[STAT_STATE_LSB +: $bits(les_state_type)] = state_reg;
		status_word[STAT_RF_BIT]             = out_reg.rf_enable;
		status_word[STAT_READY_BIT]          = out_reg.ready;
		status_word[STAT_SHUT_BIT]           = out_reg.shutter_open_indication;
		ctrl_next     = ctrl_reg;
		irq_mask_next = irq_mask_reg;
		if (wr && addr_is(paddr, ADDR_CTRL))
			ctrl_next = pwdata & CTRL_MASK;
		if (wr && addr_is(paddr, ADDR_IRQ_MASK))
			irq_mask_next = pwdata[IRQ_W-1:0];
		// Clear only what was returned, so an event during the access survives
		irq_stat_next = irq_stat_reg;
		if (rd && addr_is(paddr, ADDR_IRQ_STAT))
			irq_stat_next = irq_stat_reg & ~prdata_reg[IRQ_W-1:0];
		irq_stat_next = irq_stat_next | events;
		irq_next      = |(irq_stat_next & irq_mask_next);
		hit         = 1'b1;
		prdata_next = '0;
		if (addr_is(paddr, ADDR_CTRL))
			prdata_next = ctrl_reg;
		else if (addr_is(paddr, ADDR_STATUS))
			prdata_next = status_word;
		else if (addr_is(paddr, ADDR_IRQ_STAT))
			prdata_next[IRQ_W-1:0] = irq_stat_reg;
		else if (addr_is(paddr, ADDR_IRQ_MASK))
			prdata_next[IRQ_W-1:0] = irq_mask_reg;
		else if (addr_is(paddr, ADDR_PWM_HIGH))
			prdata_next[PWM_W-1:0] = pwm_high_reg;
		else if (addr_is(paddr, ADDR_PWM_PER))
			prdata_next[PWM_W-1:0] = pwm_per_reg;
		else
			hit = 1'b0;
		if (!setup || pwrite)
			prdata_next = setup ? '0 : prdata_reg;
		pready_next  = setup;
		pslverr_next = setup & ~hit;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg     <= CTRL_RST;
			irq_stat_reg <= IRQ_RST;
			irq_mask_reg <= IRQ_RST;
			prdata_reg   <= '0;
			pready_reg   <= 1'b0;
			pslverr_reg  <= 1'b0;
			irq_reg      <= 1'b0;
		end else begin
			ctrl_reg     <= ctrl_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			prdata_reg   <= prdata_next;
			pready_reg   <= pready_next;
			pslverr_reg  <= pslverr_next;
			irq_reg      <= irq_next;
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq     = irq_reg;

	// ============================================================
	// Assertions
	// held request disables
	hold_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		pin.reset_req |-> ##1 (!out_reg.rf_enable && !out_reg.laser_pwm))
		else $error("laser enabled while reset request held");
	ready_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		($fell(pin.reset_req) && (!ks || (pin.keyswitch_on && pin.interlock)))
		|-> ##1 out_reg.ready)
		else $error("ready not set after request release");
	delay_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_DELAY) |-> ##1 !out_reg.rf_enable)
		else $error("emission during restart delay");
	req_release_a: assert property (@(posedge pclk) disable iff (!presetn)
		out_reg.rf_enable |-> !$past(pin.reset_req))
		else $error("rf power on while request was active");
	delay_end_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_DELAY && delay_cnt_reg == DELAY_LAST && !pin.reset_req
		&& pin.interlock && pin.keyswitch_on) |-> ##1 (state_reg == ST_RUN))
		else $error("delay expiry did not enable run");
	il_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		!pin.interlock |-> ##1 !out_reg.rf_enable)
		else $error("rf power on without interlock");
	il_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ks && $fell(pin.interlock) && !pin.reset_req
		&& (state_reg == ST_RUN || state_reg == ST_DELAY)) |-> ##1 (state_reg == ST_LATCHED))
		else $error("interlock drop not latched");
	oem_return_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!ks && state_reg == ST_RUN && $rose(pin.interlock) && shutter_ok
		&& !pin.reset_req) |-> ##1 out_reg.rf_enable)
		else $error("OEM did not enable on interlock return");
	pwm_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		out_reg.rf_enable |-> (out_reg.laser_pwm == $past(pwm_sync_reg)))
		else $error("laser drive does not follow pwm command");
	shut_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		!shutter_ok |-> ##1 (!out_reg.rf_enable && !out_reg.shutter_open_indication))
		else $error("emission with shutter closed");
	both_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
		out_reg.rf_enable |-> ($past(out_reg.ready) && $past(shutter_ok)))
		else $error("rf power without ready and shutter");
	cnt_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(state_reg == ST_DELAY) |-> (delay_cnt_reg == '0))
		else $error("restart delay counter not cleared");

endmodule

/* testbench/les_ctrl_model.sv */
// Machine controller model: drives the isolated control pins and PWM command.
// Assumes the bench sets the wanted pin levels and duty; outputs change on pclk.

`timescale 1ns/1ps

module les_ctrl_model
	import les_pkg::*;
#(
	parameter int unsigned PWM_PERIOD = 2000
) (
	input  wire logic                  pclk,     // Controller clock
	input  wire les_pkg::les_pins_type pins_cmd, // Wanted pin levels
	input  wire logic [6:0]            duty_pct, // PWM duty in percent
	output les_pkg::les_pins_type      pins_in,  // Pins to the device
	output logic                       pwm_in    // PWM command
);
	logic [15:0] cnt;
	logic [31:0] high_cyc;

	assign high_cyc = PWM_PERIOD * duty_pct / 100;

	initial begin
		pins_in = '0;
		pwm_in  = 1'b0;
		cnt     = 16'h0000;
	end

	// ============================================================
	// nominal PWM rate
	// At 10 MHz a 2000-cycle period is the 5 kHz nominal, well under the ceiling
	always @(posedge pclk) begin
		cnt     <= (cnt == PWM_PERIOD - 1) ? 16'h0000 : cnt + 16'h0001;
		pwm_in  <= (32'(cnt) < high_cyc);
		pins_in <= pins_cmd;
	end
endmodule

/* testbench/les_sequencer_tb.sv */
// Self-checking bench of the sequencer: APB master, pin scenarios, PWM checks.
// Assumes the controller model and the sequencer with short delay parameters.

`timescale 1ns/1ps

module les_sequencer_tb;
	import les_pkg::*;

	localparam int unsigned DLY = 20;
	localparam int unsigned DEB = 4;
	localparam int unsigned PER = 2000;

	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, pwm_in;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, rd;
	logic         er;
	logic [6:0]   duty;
	les_pins_type cmd, pins;
	les_out_type  lo;
	int           n_errors, n_checks, cycles;

	les_ctrl_model #(.PWM_PERIOD(PER)) ctrl (.pclk(pclk), .pins_cmd(cmd), .duty_pct(duty),
		.pins_in(pins), .pwm_in(pwm_in));

	les_sequencer #(.DELAY_CYCLES(DLY), .DEB_CYCLES(DEB)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_in(pins), .pwm_in(pwm_in),
		.laser_out(lo), .irq(irq));

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'b000;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		duty = 7'd0;
		cmd = '0;
		n_errors = 0;
		n_checks = 0;
		cycles = 0;
	end

	always #50 pclk = ~pclk;

	// ============================================================
	// Checking, closing and hang guard
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish;
		if (n_errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles > 40000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	// ============================================================
	// APB master: holds the request until pready is seen high
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Pin changes pass the model flop, two sync flops and the debounce filter
	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic pin_step(input les_pins_type p, input int n);
		@(posedge pclk);
		cmd <= p;
		settle(n);
	endtask

	// ============================================================
	// Scenarios
	task automatic sc_reset_regs;
		chk(32'(lo), 32'h0);
		apb(ADDR_CTRL, 1'b0, 32'h0);
		chk(rd, 32'h1);
		apb(ADDR_IRQ_MASK, 1'b0, 32'h0);
		chk(rd, 32'h0);
		apb(8'h20, 1'b0, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
	endtask

	task automatic sc_keyswitch_start;
		pin_step(5'b11111, 12);
		chk({30'h0, lo.rf_enable, lo.ready}, 32'h0);
		pin_step(5'b11110, 12);
		chk({31'h0, lo.ready}, 32'h1);
		chk({31'h0, lo.rf_enable}, 32'h0);
		settle(8);
		chk({31'h0, lo.rf_enable}, 32'h0);
		settle(20);
		chk({31'h0, lo.rf_enable}, 32'h1);
		apb(ADDR_STATUS, 1'b0, 32'h0);
		chk({26'h0, rd[13:8]}, 32'h33);
	endtask

	task automatic sc_shutter;
		pin_step(5'b11010, 12);
		chk({30'h0, lo.rf_enable, lo.shutter_open_indication}, 32'h0);
		pin_step(5'b10110, 12);
		chk({31'h0, lo.rf_enable}, 32'h0);
		pin_step(5'b11110, 12);
		chk({30'h0, lo.rf_enable, lo.shutter_open_indication}, 32'h3);
	endtask

	task automatic sc_interlock_latch;
		apb(ADDR_IRQ_MASK, 1'b1, 32'h2);
		apb(ADDR_IRQ_STAT, 1'b0, 32'h0);
		// Ready rose, delay expired and reset request rose since power-up
		chk(rd, 32'hd);
		pin_step(5'b11100, 12);
		chk({31'h0, lo.rf_enable}, 32'h0);
		chk({31'h0, irq}, 32'h1);
		apb(ADDR_IRQ_STAT, 1'b0, 32'h0);
		chk({31'h0, rd[IRQ_IL_LOST]}, 32'h1);
		settle(2);
		chk({31'h0, irq}, 32'h0);
		pin_step(5'b11110, 40);
		chk({31'h0, lo.rf_enable}, 32'h0);
		pin_step(5'b11111, 12);
		pin_step(5'b11110, 12);
		chk({31'h0, lo.rf_enable}, 32'h0);
		settle(28);
		chk({31'h0, lo.rf_enable}, 32'h1);
	endtask

	task automatic sc_oem;
		apb(ADDR_CTRL, 1'b1, 32'h0);
		apb(ADDR_IRQ_MASK, 1'b1, 32'h0);
		pin_step(5'b11100, 12);
		chk({30'h0, lo.rf_enable, irq}, 32'h0);
		pin_step(5'b11110, 12);
		chk({31'h0, lo.rf_enable}, 32'h1);
	endtask

	task automatic sc_pwm(input logic [6:0] pct);
		int hi;
		hi = 0;
		@(posedge pclk);
		duty <= pct;
		settle(2 * PER);
		repeat (PER) begin
			@(posedge pclk);
			if (lo.laser_pwm === 1'b1)
				hi++;
		end
		chk(32'(hi), PER * pct / 100);
		apb(ADDR_PWM_HIGH, 1'b0, 32'h0);
		chk(rd, PER * pct / 100);
		apb(ADDR_PWM_PER, 1'b0, 32'h0);
		chk(rd, PER);
	endtask

	// ============================================================
	// Main sequence
	initial begin
		settle(8);
		@(posedge pclk);
		presetn <= 1'b1;
		settle(1);
		sc_reset_regs();
		sc_keyswitch_start();
		sc_shutter();
		sc_interlock_latch();
		sc_pwm(7'd50);
		sc_pwm(7'd95);
		sc_oem();
		tally_and_finish();
	end
endmodule
